// ---- verilog/pmic_event_interrupt_unit.sv ----
// event interrupt unit: debounced event flags, masks, live levels, interrupt line
`timescale 1ns/10ps
module pmic_event_interrupt_unit #(
  parameter int unsigned P_CYC_UV = pmic_irq_pkg::CYC_UV,
  parameter int unsigned P_CYC_BUTTON = pmic_irq_pkg::CYC_BUTTON,
  parameter int unsigned P_CYC_TEMP = pmic_irq_pkg::CYC_TEMP,
  parameter int unsigned P_CYC_OC = pmic_irq_pkg::CYC_OC
) (
  // clock, reset, enable
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_ce,
  // register access port
  input wire logic [pmic_irq_pkg::ADDR_W-1:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [pmic_irq_pkg::DATA_W-1:0] i_reg_wdata,
  output logic [pmic_irq_pkg::DATA_W-1:0] o_reg_rdata,
  // event sources, asynchronous
  input wire logic i_power_button_in,
  input wire logic i_supply_ok,
  input wire logic [pmic_irq_pkg::NUM_TEMP-1:0] i_temp_over,
  input wire logic [pmic_irq_pkg::NUM_BUCK-1:0] i_buck_oc,
  input wire logic i_boost_oc,
  input wire logic [pmic_irq_pkg::NUM_LDO-1:0] i_ldo_oc,
  input wire logic i_fuse_err,
  input wire logic i_fuse_prog_supply_pin,
  // interrupt line to the host
  output logic o_irq_out_n
);
  localparam int NE = pmic_irq_pkg::NUM_EVT;
  localparam int NI = pmic_irq_pkg::NUM_IN;
  localparam int DW = pmic_irq_pkg::DATA_W;
  localparam int CW = pmic_irq_pkg::CNT_W;

  logic [NI-1:0] raw_in; // gathered asynchronous inputs
  logic [NI-1:0] meta_r; // first synchroniser stage
  logic [NI-1:0] sync_r; // second synchroniser stage
  logic [NE-1:0] flag_r; // latched event flags
  logic [NE-1:0] mask_r; // event masks, 1 blocks the line
  logic [pmic_irq_pkg::SEL_W-1:0] button_fall_debounce_sel_r; // falling period stretch
  logic [DW-1:0] rdata_r; // read data
  logic [DW-1:0] rd_nxt; // read mux output
  logic [NE-1:0] evt; // debounced event pulses
  logic [NE-1:0] clr; // write-one-to-clear strobes
  logic [NE-1:0] mwe; // mask bit write enables
  logic [NE-1:0] mval; // mask bit write values
  logic sel_wr; // debounce select write
  logic [NE-1:0] keep_w; // flags not being cleared
  logic [NE-1:0] race_w; // flags set and cleared together
  logic [NE-1:0] lvl; // live levels per event
  logic [CW-1:0] uv_fall_len; // stretched undervolt period
  logic [CW-1:0] btn_fall_len; // stretched button falling period

  // gather inputs into one vector in event index order
  assign raw_in = {i_fuse_prog_supply_pin, i_fuse_err, i_ldo_oc, i_boost_oc, i_buck_oc,
                   i_temp_over, i_supply_ok, i_power_button_in};

  // two-stage synchroniser for every pin
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      meta_r <= '0;
      sync_r <= '0;
    end else if (i_ce) begin
      meta_r <= raw_in;
      sync_r <= meta_r;
    end
  end

  // live levels; undervolt level is the inverse of supply ok
  always_comb begin
    lvl = sync_r[NE-1:0];
    lvl[pmic_irq_pkg::EV_UV] = !sync_r[pmic_irq_pkg::EV_UV];
  end

  // falling periods stretched by the select field, doubling per step
  assign uv_fall_len = CW'(P_CYC_UV) << button_fall_debounce_sel_r;
  assign btn_fall_len = CW'(P_CYC_BUTTON) << button_fall_debounce_sel_r;

  // one debounce engine per event, edge and period chosen by event kind
  for (genvar k = 0; k < NE; k++) begin : g_evt
    dbnc_if u_if ();
    assign u_if.level = sync_r[k];
    assign evt[k] = u_if.hit;
    if (k == pmic_irq_pkg::EV_BUTTON) begin : g_cfg
      // both edges
      assign u_if.rise_en = 1'b1;
      assign u_if.fall_en = 1'b1;
      assign u_if.rise_len = CW'(P_CYC_BUTTON);
      assign u_if.fall_len = btn_fall_len;
    end else if (k == pmic_irq_pkg::EV_UV) begin : g_cfg
      // supply dropping only
      assign u_if.rise_en = 1'b0;
      assign u_if.fall_en = 1'b1;
      assign u_if.rise_len = CW'(P_CYC_UV);
      assign u_if.fall_len = uv_fall_len;
    end else if (k < pmic_irq_pkg::EV_BUCK0) begin : g_cfg
      // thermal thresholds, both edges
      assign u_if.rise_en = 1'b1;
      assign u_if.fall_en = 1'b1;
      assign u_if.rise_len = CW'(P_CYC_TEMP);
      assign u_if.fall_len = CW'(P_CYC_TEMP);
    end else begin : g_cfg
      // overcurrent and fuse error, rising only
      assign u_if.rise_en = 1'b1;
      assign u_if.fall_en = 1'b0;
      assign u_if.rise_len = CW'(P_CYC_OC);
      assign u_if.fall_len = CW'(P_CYC_OC);
    end
    event_debouncer u_db (
      .i_clk(i_clk),
      .i_rst_b(i_rst_b),
      .i_ce(i_ce),
      .bus(u_if.engine)
    );
  end

  // write decode into clear strobes and mask writes
  always_comb begin
    clr = '0;
    mwe = '0;
    mval = '0;
    sel_wr = 1'b0;
    if (i_reg_wr) begin
      if (i_reg_addr == pmic_irq_pkg::ADDR_FLAGS0) begin
        clr[pmic_irq_pkg::GRP0_W-1:0] = i_reg_wdata[pmic_irq_pkg::GRP0_W-1:0];
      end else if (i_reg_addr == pmic_irq_pkg::ADDR_MASKS0) begin
        mwe[pmic_irq_pkg::GRP0_W-1:0] = '1;
        mval[pmic_irq_pkg::GRP0_W-1:0] = i_reg_wdata[pmic_irq_pkg::GRP0_W-1:0];
      end else if (i_reg_addr == pmic_irq_pkg::ADDR_FLAGS1) begin
        clr[pmic_irq_pkg::EV_BUCK0 +: pmic_irq_pkg::NUM_BUCK] =
          i_reg_wdata[pmic_irq_pkg::NUM_BUCK-1:0];
      end else if (i_reg_addr == pmic_irq_pkg::ADDR_MASKS1) begin
        mwe[pmic_irq_pkg::EV_BUCK0 +: pmic_irq_pkg::NUM_BUCK] = '1;
        mval[pmic_irq_pkg::EV_BUCK0 +: pmic_irq_pkg::NUM_BUCK] =
          i_reg_wdata[pmic_irq_pkg::NUM_BUCK-1:0];
      end else if (i_reg_addr == pmic_irq_pkg::ADDR_FLAGS3) begin
        clr[pmic_irq_pkg::EV_BOOST] = i_reg_wdata[pmic_irq_pkg::BIT_BOOST];
        clr[pmic_irq_pkg::EV_FUSE] = i_reg_wdata[pmic_irq_pkg::BIT_FUSE];
      end else if (i_reg_addr == pmic_irq_pkg::ADDR_MASKS3) begin
        mwe[pmic_irq_pkg::EV_BOOST] = 1'b1;
        mwe[pmic_irq_pkg::EV_FUSE] = 1'b1;
        mval[pmic_irq_pkg::EV_BOOST] = i_reg_wdata[pmic_irq_pkg::BIT_BOOST];
        mval[pmic_irq_pkg::EV_FUSE] = i_reg_wdata[pmic_irq_pkg::BIT_FUSE];
      end else if (i_reg_addr == pmic_irq_pkg::ADDR_FLAGS4) begin
        clr[pmic_irq_pkg::EV_LDO0 +: pmic_irq_pkg::NUM_LDO] =
          i_reg_wdata[pmic_irq_pkg::NUM_LDO-1:0];
      end else if (i_reg_addr == pmic_irq_pkg::ADDR_MASKS4) begin
        mwe[pmic_irq_pkg::EV_LDO0 +: pmic_irq_pkg::NUM_LDO] = '1;
        mval[pmic_irq_pkg::EV_LDO0 +: pmic_irq_pkg::NUM_LDO] =
          i_reg_wdata[pmic_irq_pkg::NUM_LDO-1:0];
      end else if (i_reg_addr == pmic_irq_pkg::ADDR_DBNC_SEL) begin
        sel_wr = 1'b1;
      end
    end
  end

  assign keep_w = flag_r & ~clr;
  assign race_w = evt & clr;

  // sticky flags; a new event wins over a clear in the same cycle
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      flag_r <= pmic_irq_pkg::FLAG_RST;
    end else if (i_ce) begin
      flag_r <= keep_w | evt;
    end
  end

  // masks, written bit by bit through the enables
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      mask_r <= pmic_irq_pkg::MASK_RST;
    end else if (i_ce) begin
      mask_r <= (mask_r & ~mwe) | (mval & mwe);
    end
  end

  // debounce select field
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      button_fall_debounce_sel_r <= pmic_irq_pkg::SEL_RST;
    end else if (i_ce && sel_wr) begin
      button_fall_debounce_sel_r <= i_reg_wdata[pmic_irq_pkg::SEL_W-1:0];
    end
  end

  // read mux; unused bits and unmapped offsets read zero
  always_comb begin
    rd_nxt = '0;
    if (i_reg_addr == pmic_irq_pkg::ADDR_FLAGS0) begin
      rd_nxt[pmic_irq_pkg::GRP0_W-1:0] = flag_r[pmic_irq_pkg::GRP0_W-1:0];
    end else if (i_reg_addr == pmic_irq_pkg::ADDR_MASKS0) begin
      rd_nxt[pmic_irq_pkg::GRP0_W-1:0] = mask_r[pmic_irq_pkg::GRP0_W-1:0];
    end else if (i_reg_addr == pmic_irq_pkg::ADDR_LEVELS0) begin
      rd_nxt[pmic_irq_pkg::GRP0_W-1:0] = lvl[pmic_irq_pkg::GRP0_W-1:0];
      rd_nxt[pmic_irq_pkg::BIT_FUSE_SUPPLY] = sync_r[pmic_irq_pkg::IDX_FUSE_SUPPLY];
    end else if (i_reg_addr == pmic_irq_pkg::ADDR_FLAGS1) begin
      rd_nxt[pmic_irq_pkg::NUM_BUCK-1:0] = flag_r[pmic_irq_pkg::EV_BUCK0 +: pmic_irq_pkg::NUM_BUCK];
    end else if (i_reg_addr == pmic_irq_pkg::ADDR_MASKS1) begin
      rd_nxt[pmic_irq_pkg::NUM_BUCK-1:0] = mask_r[pmic_irq_pkg::EV_BUCK0 +: pmic_irq_pkg::NUM_BUCK];
    end else if (i_reg_addr == pmic_irq_pkg::ADDR_LEVELS1) begin
      rd_nxt[pmic_irq_pkg::NUM_BUCK-1:0] = lvl[pmic_irq_pkg::EV_BUCK0 +: pmic_irq_pkg::NUM_BUCK];
    end else if (i_reg_addr == pmic_irq_pkg::ADDR_FLAGS3) begin
      rd_nxt[pmic_irq_pkg::BIT_BOOST] = flag_r[pmic_irq_pkg::EV_BOOST];
      rd_nxt[pmic_irq_pkg::BIT_FUSE] = flag_r[pmic_irq_pkg::EV_FUSE];
    end else if (i_reg_addr == pmic_irq_pkg::ADDR_MASKS3) begin
      rd_nxt[pmic_irq_pkg::BIT_BOOST] = mask_r[pmic_irq_pkg::EV_BOOST];
      rd_nxt[pmic_irq_pkg::BIT_FUSE] = mask_r[pmic_irq_pkg::EV_FUSE];
    end else if (i_reg_addr == pmic_irq_pkg::ADDR_LEVELS3) begin
      rd_nxt[pmic_irq_pkg::BIT_BOOST] = lvl[pmic_irq_pkg::EV_BOOST];
      rd_nxt[pmic_irq_pkg::BIT_FUSE] = lvl[pmic_irq_pkg::EV_FUSE];
    end else if (i_reg_addr == pmic_irq_pkg::ADDR_FLAGS4) begin
      rd_nxt[pmic_irq_pkg::NUM_LDO-1:0] = flag_r[pmic_irq_pkg::EV_LDO0 +: pmic_irq_pkg::NUM_LDO];
    end else if (i_reg_addr == pmic_irq_pkg::ADDR_MASKS4) begin
      rd_nxt[pmic_irq_pkg::NUM_LDO-1:0] = mask_r[pmic_irq_pkg::EV_LDO0 +: pmic_irq_pkg::NUM_LDO];
    end else if (i_reg_addr == pmic_irq_pkg::ADDR_LEVELS4) begin
      rd_nxt[pmic_irq_pkg::NUM_LDO-1:0] = lvl[pmic_irq_pkg::EV_LDO0 +: pmic_irq_pkg::NUM_LDO];
    end else if (i_reg_addr == pmic_irq_pkg::ADDR_DBNC_SEL) begin
      rd_nxt[pmic_irq_pkg::SEL_W-1:0] = button_fall_debounce_sel_r;
    end
  end

  // read data captured on the read strobe
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      rdata_r <= '0;
    end else if (i_ce && i_reg_rd) begin
      rdata_r <= rd_nxt;
    end
  end
  assign o_reg_rdata = rdata_r;

  // line low while any unmasked flag is set, follows mask changes at once
  assign o_irq_out_n = ~|(flag_r & ~mask_r);

  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  a_flag_sticky: assert property (i_ce |=> (flag_r & $past(keep_w)) == $past(keep_w))
    else $error("flag dropped without a clear");
  a_set_wins: assert property (i_ce && race_w != '0
    |=> (flag_r & $past(race_w)) == $past(race_w))
    else $error("event lost during a clear");
  a_unmask_irq: assert property (i_ce && mwe[0] && !mval[0] && flag_r[0] && !clr[0]
    |=> !o_irq_out_n)
    else $error("unmasked pending flag did not drive the line");
  a_reset_masked: assert property (@(posedge i_clk) disable iff (1'b0) !i_rst_b
    |=> &mask_r && flag_r == '0 && o_irq_out_n)
    else $error("reset did not mask all events");
  a_flag_cause: assert property (i_ce |=> (flag_r & ~$past(flag_r) & ~$past(evt)) == '0)
    else $error("flag set without a debounced event");
  a_level_read: assert property (i_ce && i_reg_rd
    && i_reg_addr == pmic_irq_pkg::ADDR_LEVELS0
    |=> o_reg_rdata[pmic_irq_pkg::BIT_FUSE_SUPPLY] == $past(sync_r[pmic_irq_pkg::IDX_FUSE_SUPPLY])
    && o_reg_rdata[pmic_irq_pkg::EV_UV] == !$past(sync_r[pmic_irq_pkg::EV_UV]))
    else $error("level register does not mirror inputs");
  a_uv_clear: assert property (i_ce && clr[pmic_irq_pkg::EV_UV] && !evt[pmic_irq_pkg::EV_UV]
    |=> !flag_r[pmic_irq_pkg::EV_UV])
    else $error("undervolt flag not cleared by write one");
  a_buck_clear: assert property (i_ce && i_reg_wr && i_reg_addr == pmic_irq_pkg::ADDR_FLAGS1
    && i_reg_wdata[0] && !evt[pmic_irq_pkg::EV_BUCK0] |=> !flag_r[pmic_irq_pkg::EV_BUCK0])
    else $error("buck flag not cleared by write one");

  c_irq_low: cover property ($fell(o_irq_out_n));
  c_race: cover property (i_ce && race_w != '0);
  c_unmask: cover property (i_ce && mwe[0] && !mval[0] && flag_r[0]);
endmodule : pmic_event_interrupt_unit

// ---- shared/pmic_irq_pkg.sv ----
// constants for the event interrupt unit: register map, event indices, debounce timing
package pmic_irq_pkg;
  // data path and counter widths
  localparam int DATA_W = 8;
  localparam int ADDR_W = 8;
  localparam int CNT_W = 26;
  localparam int SEL_W = 2;
  // event indices inside the flag and mask vectors
  localparam int NUM_EVT = 21;
  localparam int EV_BUTTON = 0;
  localparam int EV_UV = 1;
  localparam int EV_TEMP0 = 2;
  localparam int NUM_TEMP = 4;
  localparam int GRP0_W = 6;
  localparam int EV_BUCK0 = 6;
  localparam int NUM_BUCK = 7;
  localparam int EV_BOOST = 13;
  localparam int EV_LDO0 = 14;
  localparam int NUM_LDO = 6;
  localparam int EV_FUSE = 20;
  // synchronised input carrying the fuse programming supply level
  localparam int IDX_FUSE_SUPPLY = 21;
  localparam int NUM_IN = 22;
  // bit positions inside the third register group and the level register
  localparam int BIT_BOOST = 0;
  localparam int BIT_FUSE = 7;
  localparam int BIT_FUSE_SUPPLY = 7;
  // register offsets
  localparam logic [ADDR_W-1:0] ADDR_FLAGS0 = 8'h05;
  localparam logic [ADDR_W-1:0] ADDR_MASKS0 = 8'h06;
  localparam logic [ADDR_W-1:0] ADDR_LEVELS0 = 8'h07;
  localparam logic [ADDR_W-1:0] ADDR_FLAGS1 = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_MASKS1 = 8'h09;
  localparam logic [ADDR_W-1:0] ADDR_LEVELS1 = 8'h0A;
  localparam logic [ADDR_W-1:0] ADDR_FLAGS3 = 8'h0E;
  localparam logic [ADDR_W-1:0] ADDR_MASKS3 = 8'h0F;
  localparam logic [ADDR_W-1:0] ADDR_LEVELS3 = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_FLAGS4 = 8'h11;
  localparam logic [ADDR_W-1:0] ADDR_MASKS4 = 8'h12;
  localparam logic [ADDR_W-1:0] ADDR_LEVELS4 = 8'h13;
  localparam logic [ADDR_W-1:0] ADDR_DBNC_SEL = 8'h14;
  // reset values
  localparam logic [NUM_EVT-1:0] FLAG_RST = {NUM_EVT{1'b0}};
  localparam logic [NUM_EVT-1:0] MASK_RST = {NUM_EVT{1'b1}};
  localparam logic [SEL_W-1:0] SEL_RST = 2'h0;
  localparam logic [CNT_W-1:0] CNT_RST = 26'h0;
  localparam logic [CNT_W-1:0] CNT_ONE = 26'h1;
  // debounce times as printed and the clock period
  localparam real CLK_PERIOD_NS = 10.0;
  localparam real NS_PER_MS = 1.0e6;
  localparam real T_UV_MS = 3.9;
  localparam real T_BUTTON_MS = 31.25;
  localparam real T_TEMP_MS = 3.9;
  localparam real T_OC_MS = 8.0;
  // least times, rounded up to whole cycles
  localparam int CYC_UV = int'($ceil(T_UV_MS * NS_PER_MS / CLK_PERIOD_NS));
  localparam int CYC_BUTTON = int'($ceil(T_BUTTON_MS * NS_PER_MS / CLK_PERIOD_NS));
  localparam int CYC_TEMP = int'($ceil(T_TEMP_MS * NS_PER_MS / CLK_PERIOD_NS));
  localparam int CYC_OC = int'($ceil(T_OC_MS * NS_PER_MS / CLK_PERIOD_NS));
endpackage : pmic_irq_pkg

// ---- shared/dbnc_if.sv ----
// link between the register core and one debounce engine
`timescale 1ns/10ps
interface dbnc_if;
  logic level; // synchronised event input
  logic rise_en; // low-to-high change raises an event
  logic fall_en; // high-to-low change raises an event
  logic [pmic_irq_pkg::CNT_W-1:0] rise_len; // cycles a rising change must hold
  logic [pmic_irq_pkg::CNT_W-1:0] fall_len; // cycles a falling change must hold
  logic hit; // one-cycle event pulse
  // register core side
  modport client (output level, rise_en, fall_en, rise_len, fall_len, input hit);
  // debounce engine side
  modport engine (input level, rise_en, fall_en, rise_len, fall_len, output hit);
endinterface : dbnc_if

// ---- verilog/event_debouncer.sv ----
// debounce engine: accepts a level change only after it holds for the set period
`timescale 1ns/10ps
module event_debouncer (
  // clock, reset, enable
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_ce,
  // event link
  dbnc_if.engine bus
);
  logic [pmic_irq_pkg::CNT_W-1:0] cnt_r; // cycles the new level has held
  logic stable_r; // accepted level
  logic hit_r; // event pulse
  logic [pmic_irq_pkg::CNT_W-1:0] tgt; // period for the pending change
  logic done; // pending change has held long enough

  // a falling change uses the falling period, a rising one the rising period
  assign tgt = stable_r ? bus.fall_len : bus.rise_len;
  assign done = (bus.level != stable_r) && (cnt_r == tgt - pmic_irq_pkg::CNT_ONE);
  assign bus.hit = hit_r;

  // period counter, restarts whenever the input falls back
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      cnt_r <= pmic_irq_pkg::CNT_RST;
    end else if (i_ce) begin
      if (bus.level == stable_r || done) begin
        cnt_r <= pmic_irq_pkg::CNT_RST;
      end else begin
        cnt_r <= cnt_r + pmic_irq_pkg::CNT_ONE;
      end
    end
  end

  // accepted level and edge pulse
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      stable_r <= 1'b0;
      hit_r <= 1'b0;
    end else if (i_ce) begin
      hit_r <= done && (bus.level ? bus.rise_en : bus.fall_en);
      if (done) begin
        stable_r <= bus.level;
      end
    end
  end

  // checks
  a_cnt_restart: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    i_ce && bus.level == stable_r |=> cnt_r == pmic_irq_pkg::CNT_RST)
    else $error("debounce counter did not restart");
  a_settle_time: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    $changed(stable_r) |-> $past(cnt_r) == $past(tgt) - pmic_irq_pkg::CNT_ONE)
    else $error("level accepted before the period ran out");
  a_hit_edge: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    hit_r |-> $changed(stable_r) && (stable_r ? bus.rise_en : bus.fall_en))
    else $error("event pulse on a disabled edge");
  c_accept: cover property (@(posedge i_clk) disable iff (!i_rst_b) hit_r);
endmodule : event_debouncer

// ---- verification/pmic_host_model.sv ----
// host processor model driving the register port of the event unit
`timescale 1ns/10ps
module pmic_host_model (
  // clock
  input wire logic i_clk,
  // register port toward the unit
  output logic [7:0] o_reg_addr,
  output logic o_reg_wr,
  output logic o_reg_rd,
  output logic [7:0] o_reg_wdata,
  input wire logic [7:0] i_reg_rdata
);
  // strobes idle, address and data scrambled at time zero
  initial begin
    o_reg_addr = 8'hA5;
    o_reg_wr = 1'b0;
    o_reg_rd = 1'b0;
    o_reg_wdata = 8'h5A;
  end
  // one byte written: strobe held for exactly one taking edge
  task automatic wr_byte(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    o_reg_addr <= a;
    o_reg_wdata <= d;
    o_reg_wr <= 1'b1;
    @(posedge i_clk);
    o_reg_wr <= 1'b0;
    // released lines show inverted values so stale data is never mistaken
    o_reg_addr <= ~a;
    o_reg_wdata <= ~d;
  endtask : wr_byte
  // one byte read: data taken once the answering edge has landed
  task automatic rd_byte(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clk);
    o_reg_addr <= a;
    o_reg_rd <= 1'b1;
    @(posedge i_clk);
    o_reg_rd <= 1'b0;
    o_reg_addr <= ~a;
    #1;
    d = i_reg_rdata;
  endtask : rd_byte
endmodule : pmic_host_model

// ---- verification/pmic_event_interrupt_unit_tb.sv ----
// self-checking bench for the event interrupt unit
`timescale 1ns/10ps
module pmic_event_interrupt_unit_tb;
  // shortened debounce periods handed to the unit
  localparam int UV_N = 8;
  localparam int BTN_N = 16;
  localparam int TMP_N = 8;
  localparam int OC_N = 12;
  localparam int LIMIT = 30000; // cycle ceiling for the whole run
  // clock, reset, event sources packed in flag order
  logic i_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic [21:0] src = 22'h0;
  logic [7:0] addr, wdata, rdata, rd_v;
  logic wr, rd, irq_n;
  logic ce = 1'b1; // clock enable, dropped once to prove writes are refused
  int num_errors = 0;
  int checked = 0;
  int cyc = 0;
  logic [31:0] seed = 32'h13;
  // clock at 100 MHz
  always #5 i_clk = ~i_clk;
  // host on the register port
  pmic_host_model host_u (.i_clk(i_clk), .o_reg_addr(addr), .o_reg_wr(wr), .o_reg_rd(rd),
    .o_reg_wdata(wdata), .i_reg_rdata(rdata));
  // unit under test with short periods
  pmic_event_interrupt_unit #(.P_CYC_UV(UV_N), .P_CYC_BUTTON(BTN_N), .P_CYC_TEMP(TMP_N),
    .P_CYC_OC(OC_N)) dut_u (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_ce(ce), .i_reg_addr(addr), .i_reg_wr(wr),
    .i_reg_rd(rd), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
    .i_power_button_in(src[0]), .i_supply_ok(~src[1]), .i_temp_over(src[5:2]),
    .i_buck_oc(src[12:6]), .i_boost_oc(src[13]), .i_ldo_oc(src[19:14]),
    .i_fuse_err(src[20]), .i_fuse_prog_supply_pin(src[21]), .o_irq_out_n(irq_n));
  // xorshift source with a fixed start
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  // debounce period of an event
  function automatic int dlen(input int k);
    return (k == 0) ? BTN_N : (k == 1) ? UV_N : (k < 6) ? TMP_N : OC_N;
  endfunction : dlen
  // flag register offset of an event
  function automatic logic [7:0] fadr(input int k);
    return (k < 6) ? 8'h05 : (k < 13) ? 8'h08 : (k == 13 || k == 20) ? 8'h0E : 8'h11;
  endfunction : fadr
  // bit of an event inside its flag register
  function automatic logic [7:0] fbit(input int k);
    return (k < 6) ? 8'h01 << k : (k < 13) ? 8'h01 << (k - 6) : (k == 13) ? 8'h01
      : (k == 20) ? 8'h80 : 8'h01 << (k - 14);
  endfunction : fbit
  // mask reset value of a register group
  function automatic logic [7:0] mdef(input logic [7:0] a);
    return (a == 8'h08) ? 8'h7F : (a == 8'h0E) ? 8'h81 : 8'h3F;
  endfunction : mdef
  // byte comparison
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk8
  // interrupt line comparison
  task automatic chk1(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk1
  // read a register and compare it
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    host_u.rd_byte(a, rd_v);
    chk8(rd_v, exp);
  endtask : rchk
  // wait whole cycles
  task automatic cyc_wait(input int n);
    repeat (n) @(posedge i_clk);
  endtask : cyc_wait
  // change one event source at a clock edge
  task automatic put(input int k, input logic v);
    @(posedge i_clk);
    src[k] <= v;
  endtask : put
  // verdict and end of run
  task automatic complete_run();
    if (num_errors == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : complete_run
  // hang guard
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      num_errors++;
      complete_run();
    end
  end
  // main sequence
  initial begin
    int k, n;
    logic [7:0] a, b;
    repeat (3) @(posedge i_clk);
    i_rst_b <= 1'b1;
    // reset values and idle line
    rchk(8'h05, 8'h00);
    rchk(8'h06, 8'h3F);
    rchk(8'h08, 8'h00);
    chk1(irq_n, 1'b1);
    // every event: glitch refused, held level latched and sticky, unmask, clear
    for (k = 0; k < 21; k++) begin
      a = fadr(k);
      b = fbit(k);
      n = dlen(k);
      put(k, 1'b1);
      cyc_wait(1 + rnd() % (n - 3));
      put(k, 1'b0);
      cyc_wait(n + 6);
      rchk(a, 8'h00);
      put(k, 1'b1);
      cyc_wait(n + 3 + rnd() % 8);
      put(k, 1'b0);
      cyc_wait(n + 6);
      rchk(a, b);
      chk1(irq_n, 1'b1);
      host_u.wr_byte(a + 8'h01, mdef(a) & ~b);
      #1 chk1(irq_n, 1'b0);
      rchk(a + 8'h01, mdef(a) & ~b);
      host_u.wr_byte(a, b);
      #1 chk1(irq_n, 1'b1);
      rchk(a, 8'h00);
      host_u.wr_byte(a + 8'h01, mdef(a));
    end
    // falling button debounce stretched four times
    host_u.wr_byte(8'h14, 8'h02);
    put(0, 1'b1);
    cyc_wait(BTN_N + 6);
    host_u.wr_byte(8'h05, 8'h01);
    put(0, 1'b0);
    cyc_wait(BTN_N * 3);
    rchk(8'h05, 8'h00);
    cyc_wait(BTN_N + 6);
    rchk(8'h05, 8'h01);
    // buck event accepted in the very cycle its flag is cleared: set wins
    put(7, 1'b1);
    cyc_wait(OC_N + 1);
    host_u.wr_byte(8'h08, 8'h02);
    rchk(8'h08, 8'h02);
    put(7, 1'b0);
    // live levels follow the inputs without latching
    repeat (4) begin
      b = 8'(rnd());
      @(posedge i_clk);
      src[5:0] <= b[5:0];
      src[12:6] <= ~b[6:0];
      src[21] <= b[7];
      cyc_wait(4);
      rchk(8'h07, {b[7], 1'b0, b[5:0]});
      rchk(8'h0A, {1'b0, ~b[6:0]});
    end
    // level register ignores writes, unmapped offset reads zero
    host_u.wr_byte(8'h07, 8'hFF);
    rchk(8'h07, {b[7], 1'b0, b[5:0]});
    rchk(8'h20, 8'h00);
    // a write while the clock enable is low is refused
    @(posedge i_clk);
    ce <= 1'b0;
    host_u.wr_byte(8'h06, 8'h00);
    @(posedge i_clk);
    ce <= 1'b1;
    rchk(8'h06, 8'h3F);
    chk1(irq_n, 1'b1);
    complete_run();
  end
endmodule : pmic_event_interrupt_unit_tb
